// *** sed_pkg.sv ***
package sed_pkg;

    // opcodes
    localparam logic [7:0] OP_SET_LATCH  = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STATUS_RD  = 8'h05;
    localparam logic [7:0] OP_STATUS_WR  = 8'h01;
    localparam logic [7:0] OP_ARRAY_RD   = 8'h03;
    localparam logic [7:0] OP_ARRAY_WR   = 8'h02;
    localparam logic [7:0] OP_ID_RD      = 8'h83;
    localparam logic [7:0] OP_ID_WR      = 8'h82;

    // address layout
    localparam int         ARRAY_MSB     = 14;
    localparam int         ID_MSB        = 5;
    localparam int         ID_SEL_BIT    = 10;
    localparam int         ID_PAGE_BYTES = 64;
    localparam int         ID_CODE_BYTES = 3;
    localparam logic [7:0] ID_FILL       = 8'hFF;

    // status byte layout
    localparam int         SR_PROTECT    = 7;
    localparam int         SR_GUARD_HI   = 3;
    localparam int         SR_GUARD_LO   = 2;
    localparam int         SR_LATCH      = 1;
    localparam int         SR_BUSY       = 0;
    localparam logic [7:0] SR_RESET      = 8'h00;
    localparam logic [1:0] GUARD_ALL     = 2'h3;

    // timing
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned TW_MS        = 4;
    localparam int unsigned TW_CYCLES    = TW_MS * (CLK_HZ / 1000);
    localparam int          TW_W         = 16;

    typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DIN, PH_DOUT, PH_END, PH_WAIT} sed_phase_t;
    typedef enum logic [2:0] {K_NONE, K_SET, K_CLR, K_STATUS_WR, K_ARRAY_WR, K_ID_WR, K_LOCK} sed_kind_t;

endpackage : sed_pkg

// *** sed_sync.sv ***
`timescale 1ns/100ps
module sed_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sed_sync_t;

    sed_sync_t r;
    sed_sync_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = d_in;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_out = r.s2;

endmodule : sed_sync

// *** sed_decoder.sv ***
// Behaviour
// - separate 64-byte identification page
// - first three page bytes hold identity codes
// - whole bytes, msb first, opcode first
// - undefined opcode waits until deselect
// - latch set/clear and status read opcodes
// - status write, array read/write opcodes
// - 0x83/0x82 split by address bit 10
// - array address two bytes, bit15 ignored
// - id page uses address bits 5..0
// - lock commands carry address bit 10 set
// - set-latch then deselect sets latch
// - clear-latch then deselect clears latch
// - clear-latch works during write cycle
// - status read repeats while selected
// - status read accepted while busy
// - status bits change after write cycle
// - status write keeps bits 6,5,4,1,0
// - busy rejects status write, array read
// - array read streams incrementing addresses
// - array address wraps to zero
// - deselect stops data output anytime
// - sample rising edge, shift falling edge
// - busy flag high during write cycle
// - latch cleared: reset, clear, write end
// - writes need byte-boundary end, data byte
`timescale 1ns/100ps
module sed_decoder
    import sed_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = TW_CYCLES,
    parameter logic [7:0]  ID_MAKER     = 8'hA5,   // arbitrary value
    parameter logic [7:0]  ID_FAMILY    = 8'h5A,   // arbitrary value
    parameter logic [7:0]  ID_DENSITY   = 8'h3C    // arbitrary value
) (
    input  wire logic                 CLK_IN,
    input  wire logic                 RSTN_IN,
    input  wire logic                 SPI_CLK_IN,
    input  wire logic                 CSN_IN,
    input  wire logic                 SDI_IN,
    output logic                      SDO_OUT,
    output logic                      SDO_OE_OUT,
    output logic [ARRAY_MSB:0]        ARRAY_ADDR_OUT,
    input  wire logic [7:0]           ARRAY_DATA_IN,
    input  wire logic                 LOCK_STATE_IN,
    output logic [7:0]                STATUS_OUT,
    output logic                      WE_LATCH_OUT,
    output logic                      WRITE_BUSY_OUT,
    output logic                      STATUS_PROTECT_OUT,
    output logic [1:0]                BLOCK_GUARD_OUT,
    output logic [2:0]                WRITE_KIND_OUT,
    output logic [15:0]               WRITE_ADDR_OUT,
    output logic [7:0]                WRITE_DATA_OUT
);

    // ---------------- link domain (serial clock) ----------------
    typedef struct packed {
        sed_phase_t  phase;
        logic [2:0]  bits;
        logic [7:0]  sh;
        logic [7:0]  op;
        logic        hi_done;
        logic [15:0] addr;
        logic [7:0]  tx;
        logic        got_data;
        logic [7:0]  din_byte;
        logic        tog;
    } sed_link_t;

    sed_link_t   lk;
    sed_link_t   next_lk;
    logic        fs;
    logic        fs_set;
    logic [5:0]  lsync;
    logic        q;
    logic        q_en;
    logic [15:0] rd_addr;
    logic [7:0]  status_s;
    logic        busy_s;
    logic        lock_s;
    logic        res_ok;
    sed_kind_t   res_kind;

    function automatic logic [7:0] id_byte(input logic [ID_MSB:0] idx);
        case (idx)
            6'h00:   id_byte = ID_MAKER;
            6'h01:   id_byte = ID_FAMILY;
            6'h02:   id_byte = ID_DENSITY;
            default: id_byte = ID_FILL;
        endcase
    endfunction : id_byte

    function automatic sed_kind_t cmd_kind(input logic [7:0] op, input logic [15:0] a);
        case (op)
            OP_SET_LATCH: cmd_kind = K_SET;
            OP_CLR_LATCH: cmd_kind = K_CLR;
            OP_STATUS_WR: cmd_kind = K_STATUS_WR;
            OP_ARRAY_WR:  cmd_kind = K_ARRAY_WR;
            OP_ID_WR:     cmd_kind = a[ID_SEL_BIT] ? K_LOCK : K_ID_WR;
            default:      cmd_kind = K_NONE;
        endcase
    endfunction : cmd_kind

    // status bits and lock level enter the link domain one flag per bit
    sed_sync #(.WIDTH(6)) u_link_sync (
        .clk_in  (SPI_CLK_IN),
        .rstn_in (RSTN_IN),
        .d_in    ({LOCK_STATE_IN, STATUS_OUT[SR_PROTECT], STATUS_OUT[SR_GUARD_HI],
                   STATUS_OUT[SR_GUARD_LO], STATUS_OUT[SR_LATCH], STATUS_OUT[SR_BUSY]}),
        .q_out   (lsync)
    );

    assign lock_s   = lsync[5];
    assign busy_s   = lsync[0];
    assign status_s = {lsync[4], 3'h0, lsync[3], lsync[2], lsync[1], lsync[0]};

    // frame start marker; the serial clock may stop while deselected
    assign fs_set = CSN_IN | ~RSTN_IN;

    always_ff @(posedge SPI_CLK_IN or posedge fs_set) begin
        if (fs_set) begin
            fs <= 1'b1;
        end else begin
            fs <= 1'b0;
        end
    end

    always_comb begin
        logic [2:0]  b;
        sed_phase_t  ph;
        logic [7:0]  byte_in;
        logic [7:0]  cur_op;
        logic        last;
        logic        load;
        b            = fs ? 3'h0 : lk.bits;
        ph           = fs ? PH_CMD : lk.phase;
        byte_in      = {lk.sh[6:0], SDI_IN};
        last         = (b == 3'h7);
        load         = 1'b0;
        cur_op       = (ph == PH_CMD) ? byte_in : lk.op;
        rd_addr      = lk.addr;
        next_lk      = lk;
        next_lk.bits = 3'(b + 3'h1);
        next_lk.sh   = byte_in;
        next_lk.phase = ph;
        if (fs) begin
            next_lk.hi_done  = 1'b0;
            next_lk.got_data = 1'b0;
            next_lk.tog      = ~lk.tog;
        end
        case (ph)
            PH_CMD: begin
                if (last) begin
                    next_lk.op = byte_in;
                    case (byte_in)
                        OP_SET_LATCH, OP_CLR_LATCH: next_lk.phase = PH_END;
                        OP_STATUS_RD: begin
                            next_lk.phase = PH_DOUT;
                            load          = 1'b1;
                        end
                        OP_STATUS_WR: next_lk.phase = busy_s ? PH_WAIT : PH_DIN;
                        OP_ARRAY_RD, OP_ARRAY_WR, OP_ID_RD, OP_ID_WR:
                            next_lk.phase = busy_s ? PH_WAIT : PH_ADDR;
                        default: next_lk.phase = PH_WAIT;
                    endcase
                end
            end
            PH_ADDR: begin
                if (last) begin
                    if (!lk.hi_done) begin
                        next_lk.addr[15:8] = byte_in;
                        next_lk.hi_done    = 1'b1;
                    end else begin
                        rd_addr           = {lk.addr[15:8], byte_in};
                        next_lk.addr[7:0] = byte_in;
                        if (lk.op == OP_ARRAY_RD || lk.op == OP_ID_RD) begin
                            next_lk.phase = PH_DOUT;
                            load          = 1'b1;
                        end else begin
                            next_lk.phase = PH_DIN;
                        end
                    end
                end
            end
            PH_DIN: begin
                if (last) begin
                    next_lk.got_data = 1'b1;
                    next_lk.din_byte = byte_in;
                end
            end
            PH_DOUT: begin
                load = last;
            end
            PH_END:  next_lk.phase = PH_WAIT;
            PH_WAIT: next_lk.phase = PH_WAIT;
            default: next_lk.phase = PH_WAIT;
        endcase
        if (load) begin
            case (cur_op)
                OP_STATUS_RD: next_lk.tx = status_s;
                OP_ARRAY_RD: begin
                    next_lk.tx               = ARRAY_DATA_IN;
                    next_lk.addr[ARRAY_MSB:0] = rd_addr[ARRAY_MSB:0] + 15'h0001;
                end
                default: begin
                    if (rd_addr[ID_SEL_BIT]) begin
                        next_lk.tx = {7'h00, lock_s};
                    end else begin
                        next_lk.tx              = id_byte(rd_addr[ID_MSB:0]);
                        next_lk.addr[ID_MSB:0] = rd_addr[ID_MSB:0] + 6'h01;
                    end
                end
            endcase
        end
        // an edge while deselected (polarity change) must not count as a frame
        if (CSN_IN) begin
            next_lk = lk;
        end
    end

    always_ff @(posedge SPI_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // output shifts on the falling edge, half a clock ahead of sampling
    always_ff @(negedge SPI_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            q    <= 1'b0;
            q_en <= 1'b0;
        end else begin
            q    <= lk.tx[3'h7 - lk.bits];
            q_en <= !fs && (lk.phase == PH_DOUT);
        end
    end

    assign SDO_OUT        = q;
    assign SDO_OE_OUT     = q_en & ~CSN_IN;
    assign ARRAY_ADDR_OUT = rd_addr[ARRAY_MSB:0];

    // quasi-static: read by the core only after deselect, clock stopped
    assign res_ok   = (lk.bits == 3'h0) &&
                      ((lk.phase == PH_END) || (lk.phase == PH_DIN && lk.got_data));
    assign res_kind = res_ok ? cmd_kind(lk.op, lk.addr) : K_NONE;

    // ---------------- core domain ----------------
    typedef struct packed {
        logic            csn_d;
        logic            seen;
        logic            write_enable_latch;
        logic            busy;
        logic            status_protect_bit;
        logic [1:0]      bp;
        logic [TW_W-1:0] cnt;
        sed_kind_t       kind;
        logic [7:0]      data;
        logic [15:0]     waddr;
    } sed_core_t;

    sed_core_t  ck;
    sed_core_t  next_ck;
    logic [1:0] csync;
    logic       cs_rise;
    logic       fresh;

    sed_sync #(.WIDTH(2)) u_core_sync (
        .clk_in  (CLK_IN),
        .rstn_in (RSTN_IN),
        .d_in    ({lk.tog, ~CSN_IN}),
        .q_out   (csync)
    );

    // select enters active high so the cleared flops match the idle pin
    assign cs_rise = ~csync[0] & ~ck.csn_d;
    assign fresh   = csync[1] ^ ck.seen;

    always_comb begin
        next_ck       = ck;
        next_ck.csn_d = ~csync[0];
        if (ck.busy) begin
            next_ck.cnt = TW_W'(ck.cnt - 1'b1);
            if (ck.cnt == TW_W'(1)) begin
                next_ck.busy = 1'b0;
                next_ck.write_enable_latch  = 1'b0;
                if (ck.kind == K_STATUS_WR) begin
                    next_ck.status_protect_bit = ck.data[SR_PROTECT];
                    next_ck.bp   = ck.data[SR_GUARD_HI:SR_GUARD_LO];
                end
            end
        end
        if (cs_rise && fresh) begin
            next_ck.seen = csync[1];
            case (res_kind)
                K_SET: next_ck.write_enable_latch = 1'b1;
                K_CLR: next_ck.write_enable_latch = 1'b0;
                K_STATUS_WR, K_ARRAY_WR, K_ID_WR, K_LOCK: begin
                    // guard-all also freezes the id page and its lock
                    if (ck.write_enable_latch && !ck.busy &&
                        !((res_kind == K_ID_WR || res_kind == K_LOCK) && ck.bp == GUARD_ALL)) begin
                        next_ck.busy  = 1'b1;
                        next_ck.cnt   = TW_W'(WRITE_CYCLES);
                        next_ck.kind  = res_kind;
                        next_ck.data  = lk.din_byte;
                        next_ck.waddr = lk.addr;
                    end
                end
                default: next_ck.seen = csync[1];
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ck       <= '0;
            ck.csn_d <= 1'b1;
            ck.status_protect_bit  <= SR_RESET[SR_PROTECT];
            ck.bp    <= SR_RESET[SR_GUARD_HI:SR_GUARD_LO];
        end else begin
            ck <= next_ck;
        end
    end

    assign STATUS_OUT         = {ck.status_protect_bit, 3'h0, ck.bp, ck.write_enable_latch, ck.busy};
    assign WE_LATCH_OUT       = ck.write_enable_latch;
    assign WRITE_BUSY_OUT     = ck.busy;
    assign STATUS_PROTECT_OUT = ck.status_protect_bit;
    assign BLOCK_GUARD_OUT    = ck.bp;
    assign WRITE_KIND_OUT     = ck.kind;
    assign WRITE_ADDR_OUT     = ck.waddr;
    assign WRITE_DATA_OUT     = ck.data;

    // ---------------- checks ----------------
    sequence s_cmd_end(sed_kind_t k);
        cs_rise && fresh && res_kind == k;
    endsequence

    a_busy_holds: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        $rose(ck.busy) |-> ck.busy [*8])
        else $error("busy flag dropped too early");
    a_latch_set: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_cmd_end(K_SET) |=> ck.write_enable_latch)
        else $error("latch not set after set command");
    a_latch_clear: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_cmd_end(K_CLR) |=> !ck.write_enable_latch && ck.busy == ($past(ck.busy) && $past(ck.cnt) != TW_W'(1)))
        else $error("clear command failed or disturbed write");
    a_status_late: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        (ck.busy && ck.cnt != TW_W'(1)) |=> $stable({ck.status_protect_bit, ck.bp}))
        else $error("status bits changed during write cycle");
    a_end_clears: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        $fell(ck.busy) |-> !ck.write_enable_latch || $past(cs_rise && fresh && res_kind == K_SET))
        else $error("latch left set after write cycle");
    a_busy_reject: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        (ck.busy && ck.cnt != TW_W'(1) && cs_rise && fresh) |=>
        $stable(ck.kind) && $stable(ck.data) && $stable(ck.waddr))
        else $error("write accepted while busy");
    a_wait_sticks: assert property (@(posedge SPI_CLK_IN) disable iff (!RSTN_IN || CSN_IN)
        (lk.phase == PH_WAIT && !fs) |=> lk.phase == PH_WAIT && !SDO_OE_OUT)
        else $error("wait state left while selected");
    a_addr_wrap: assert property (@(posedge SPI_CLK_IN) disable iff (!RSTN_IN || CSN_IN)
        (!fs && lk.phase == PH_DOUT && lk.op == OP_ARRAY_RD && lk.bits == 3'h7 &&
         lk.addr[ARRAY_MSB:0] == 15'h7FFF) |=> lk.addr[ARRAY_MSB:0] == 15'h0000)
        else $error("array address did not wrap");
    a_deselect_quiet: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        CSN_IN |-> !SDO_OE_OUT)
        else $error("data driven while deselected");

endmodule : sed_decoder

// *** sed_spi_master.sv ***
`timescale 1ns/100ps
module sed_spi_master (
    output logic      sclk_out,
    output logic      csn_out,
    output logic      sdi_out,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in
);

    initial begin
        sclk_out = 1'b0;
        csn_out  = 1'b1;
        sdi_out  = 1'b0;
    end

    // clock stands at cpol outside frames; ntx bits sent, nrx bits read back
    task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx, input logic cpol,
                        output logic [31:0] rx, output int oe_hi);
        int i;
        rx       = '0;
        oe_hi    = 0;
        sclk_out = cpol;
        #3;
        csn_out  = 1'b0;
        for (i = 0; i < ntx + nrx; i++) begin
            // leading fall is a real edge only when idling high
            sclk_out = 1'b0;
            // msb first; past the ntx sent bits the line toggles every bit
            sdi_out  = (i < ntx) ? tx[31-i] : ~sdi_out;
            #7.5;
            sclk_out = 1'b1;
            if (i >= ntx) begin
                rx    = {rx[30:0], sdo_in};
                oe_hi = oe_hi + ((sdo_oe_in === 1'b1) ? 1 : 0);
            end
            #7.5;
        end
        sclk_out = cpol;
        #7.5;
        csn_out = 1'b1;
        sdi_out = ~sdi_out;
        // deselect gap long enough for the core to see it
        #500;
    endtask : xfer

endmodule : sed_spi_master

// *** sed_decoder_tb.sv ***
`timescale 1ns/100ps
module sed_decoder_tb;
    import sed_pkg::*;

    localparam int unsigned WCYC = 64;

    logic             clk = 1'b0;
    logic             rstn;
    logic             lock_state;
    logic             sclk;
    logic             csn;
    logic             sdi;
    logic             sdo;
    logic             sdo_oe;
    logic [14:0]      array_addr;
    logic [7:0]       array_data;
    logic [7:0]       status;
    logic             we_latch;
    logic             write_busy;
    logic             status_protect;
    logic [1:0]       block_guard;
    logic [2:0]       write_kind;
    logic [15:0]      write_addr;
    logic [7:0]       write_data;
    logic [31:0]      rx;
    int               oe;
    logic [7:0]       exp_sr = 8'h00;
    logic             spi_cpol = 1'b0;
    int               miscompares = 0;
    int               check_count = 0;

    always #50 clk = ~clk;

    // array content derived from the address so wrap is visible
    assign array_data = array_addr[7:0] ^ {1'b0, array_addr[14:8]};

    sed_spi_master sed_spi_master_inst (
        .sclk_out  (sclk),
        .csn_out   (csn),
        .sdi_out   (sdi),
        .sdo_in    (sdo),
        .sdo_oe_in (sdo_oe)
    );

    sed_decoder #(.WRITE_CYCLES(WCYC)) sed_decoder_inst (
        .CLK_IN             (clk),
        .RSTN_IN            (rstn),
        .SPI_CLK_IN         (sclk),
        .CSN_IN             (csn),
        .SDI_IN             (sdi),
        .SDO_OUT            (sdo),
        .SDO_OE_OUT         (sdo_oe),
        .ARRAY_ADDR_OUT     (array_addr),
        .ARRAY_DATA_IN      (array_data),
        .LOCK_STATE_IN      (lock_state),
        .STATUS_OUT         (status),
        .WE_LATCH_OUT       (we_latch),
        .WRITE_BUSY_OUT     (write_busy),
        .STATUS_PROTECT_OUT (status_protect),
        .BLOCK_GUARD_OUT    (block_guard),
        .WRITE_KIND_OUT     (write_kind),
        .WRITE_ADDR_OUT     (write_addr),
        .WRITE_DATA_OUT     (write_data)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
        sed_spi_master_inst.xfer(tx, ntx, nrx, spi_cpol, rx, oe);
    endtask : frame

    task automatic write_cmd(input logic [31:0] tx, input int ntx, input logic [2:0] kind, input bit extra);
        int n;
        frame(32'h0600_0000, 8, 0);
        cyc(6);
        check("latch set", 32'd1, {31'd0, we_latch});
        frame(tx, ntx, 0);
        n = 0;
        while (write_busy !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        check("busy rise", 32'd1, {31'd0, write_busy});
        check("write kind", {29'd0, kind}, {29'd0, write_kind});
        frame(32'h0500_0000, 8, 16);
        check("status in busy", {16'd0, exp_sr | 8'h03, exp_sr | 8'h03}, {16'd0, rx[15:0]});
        if (extra) begin
            frame(32'h0100_0000, 16, 0);
            frame(32'h0300_0000, 24, 8);
            check("read in busy", 32'd0, oe);
            frame(32'h0400_0000, 8, 0);
            cyc(6);
            check("clear in busy", 32'd1, {30'd0, we_latch, write_busy});
        end
        n = 0;
        while (write_busy !== 1'b0 && n < 100) begin
            cyc(1);
            n++;
        end
        cyc(1);
        check("busy fall", 32'd0, {31'd0, write_busy});
        check("latch after write", 32'd0, {31'd0, we_latch});
        check("kind after write", {29'd0, kind}, {29'd0, write_kind});
    endtask : write_cmd

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    initial begin
        rstn       = 1'b0;
        lock_state = 1'b0;
        repeat (20) @(posedge clk);
        rstn       <= 1'b1;
        lock_state <= 1'b1;
        cyc(4);
        check("status reset", 32'h00, {24'd0, status});
        frame(32'h0500_0000, 8, 16);
        check("status read", 32'h0000, {16'd0, rx[15:0]});
        frame(32'h0600_0000, 8, 0);
        cyc(6);
        frame(32'h0500_0000, 8, 24);
        check("status repeat", 32'h020202, {8'd0, rx[23:0]});
        frame(32'h0400_0000, 8, 0);
        cyc(6);
        check("latch clear", 32'd0, {31'd0, we_latch});
        $display("test latch done");
        frame(32'h0600_0000, 8, 0);
        frame(32'hFF00_0000, 8, 24);
        check("undefined silent", 32'd0, oe);
        frame(32'h01FF_0000, 12, 0);
        frame(32'h0100_0000, 8, 0);
        cyc(6);
        check("discarded write", 32'h02, {24'd0, status});
        $display("test discard done");
        write_cmd(32'h02C1_2355, 32, 3'd4, 1'b1);
        check("array write addr", 32'h4123, {17'd0, write_addr[14:0]});
        check("array write data", 32'h55, {24'd0, write_data});
        write_cmd(32'h8200_0577, 32, 3'd5, 1'b0);
        write_cmd(32'h8204_0002, 32, 3'd6, 1'b0);
        write_cmd(32'h01FF_0000, 16, 3'd3, 1'b0);
        exp_sr = 8'h8C;
        check("status bits", 32'h8C, {24'd0, status});
        check("protect guard", 32'h7, {29'd0, status_protect, block_guard});
        frame(32'h0500_0000, 8, 8);
        check("status shifted", 32'h8C, {24'd0, rx[7:0]});
        $display("test writes done");
        frame(32'h03FF_FE00, 24, 32);
        check("array wrap read", 32'h8180_0001, rx);
        frame(32'h0300_1000, 24, 13);
        check("partial read", {19'd0, 8'h10, 5'b00010}, rx);
        check("released output", 32'd0, {31'd0, sdo_oe});
        frame(32'h8300_0000, 24, 32);
        check("id page read", 32'hA55A_3CFF, rx);
        frame(32'h8304_0000, 24, 16);
        check("lock status", 32'h0101, {16'd0, rx[15:0]});
        $display("test reads done");
        spi_cpol = 1'b1;
        frame(32'h0500_0000, 8, 16);
        check("idle high status", 32'h8C8C, {16'd0, rx[15:0]});
        frame(32'h0301_0200, 24, 16);
        check("idle high read", 32'h0302, {16'd0, rx[15:0]});
        $display("test idle high done");
        finish_test();
    end

endmodule : sed_decoder_tb
